// ==== uhr_pkg.sv ====
// Shared constants, field layouts and state types of the UART holding-register front end
package uhr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_HOLD   = 3'h0;
  localparam logic [2:0] IDX_MASK   = 3'h1;
  localparam logic [2:0] IDX_IDENT  = 3'h2;
  localparam logic [2:0] IDX_LCTRL  = 3'h3;
  localparam logic [2:0] IDX_MCTRL  = 3'h4;
  localparam logic [2:0] IDX_LSTATE = 3'h5;
  localparam logic [2:0] IDX_MSTATE = 3'h6;
  localparam int unsigned ADDR_W    = 5;

  // Reset values
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] IDENT_NONE  = 8'h01;
  localparam logic [7:0] LCTRL_RESET = 8'h00;

  // Field positions
  localparam int unsigned LCTRL_DIV_BIT  = 7;
  localparam logic [7:0]  LCTRL_ENH_KEY  = 8'hbf;
  localparam int unsigned ENH_UNLOCK_BIT = 4;
  localparam int unsigned FC_EN_BIT      = 0;
  localparam int unsigned FC_RXRST_BIT   = 1;
  localparam int unsigned FC_TXRST_BIT   = 2;
  localparam int unsigned MASK_SLEEP_BIT = 4;

  // Identification codes, one per source, with CTS rise and RTS rise sharing ID_FLOW
  localparam logic [5:0] ID_LINE  = 6'h06;
  localparam logic [5:0] ID_RX    = 6'h04;
  localparam logic [5:0] ID_TX    = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_XOFF  = 6'h10;
  localparam logic [5:0] ID_FLOW  = 6'h20;

  // Receive trigger levels selected by fifo_ctrl[7:6]
  localparam logic [5:0] RX_TRIG0 = 6'h01;
  localparam logic [5:0] RX_TRIG1 = 6'h08;
  localparam logic [5:0] RX_TRIG2 = 6'h10;
  localparam logic [5:0] RX_TRIG3 = 6'h1c;

  // 16x tick counts within one bit
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BIT_LAST  = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic fifo_err;
    logic tx_all_empty;
    logic tx_hold_empty;
    logic brk;
    logic frame;
    logic parity;
    logic overrun;
    logic rx_ready;
  } uhr_lstate_t;

  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} uhr_ser_t;

endpackage : uhr_pkg

// ==== uhr_core.sv ====
// UART channel: holding registers, FIFOs, serial shifters and interrupt mask on AXI4-Lite
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Holding write queues byte for the shifter
// - Transmit-empty flag set when nothing held
// - Receive holding read pops oldest byte
// - Start bit confirmed low at mid-bit
// - Mask bit 7: interrupt on CTS rise
// - Mask bit 6: interrupt on RTS rise
// - Mask bit 5 gates stop-character interrupt
// - Mask bit 4 selects sleep mode
// - Mask bit 3: any modem delta interrupts
// - Mask bit 2: receive errors interrupt
// - Mask bit 1: transmit empty interrupt
// - Mask bit 0: receive data/trigger interrupt
// - Mask register resets to zero
// - Ident shows receive at trigger level
// - Data ready set on push, cleared empty
// - Transmit interrupt cleared by ident read/holding write
// - Enabled requests drive channel interrupt pin
// - Mask bits 7:4 need enhanced unlock
// - Mask reachable only with divisor access off
module uhr_core
  import uhr_pkg::*;
#(
  parameter int unsigned DEPTH         = 32,
  parameter int unsigned CLKS_PER_TICK = 4,
  parameter logic [7:0]  XOFF_CHAR     = 8'h13
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rxd,
  input  wire logic              cts_pin,
  input  wire logic              dsr_pin,
  input  wire logic              ri_pin,
  input  wire logic              cd_pin,
  output logic                   txd,
  output logic                   rts_pin,
  output logic                   dtr_pin,
  output logic                   sleep_out,
  output logic                   irq_out_chan_a
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = PW + 1;

  if (DEPTH < 2 || (1 << PW) != DEPTH || CLKS_PER_TICK < 1 || CLKS_PER_TICK > 65535) begin : g_chk
    $error("uhr_core: DEPTH must be a power of two >= 2, CLKS_PER_TICK 1..65535");
  end

  function automatic logic [CW-1:0] fifo_lim(input logic en);
    fifo_lim = en ? CW'(DEPTH) : CW'(1);
  endfunction : fifo_lim

  function automatic logic [CW-1:0] trig_of(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_of = CW'(RX_TRIG0);
      2'h1:    trig_of = CW'(RX_TRIG1);
      2'h2:    trig_of = CW'(RX_TRIG2);
      default: trig_of = CW'(RX_TRIG3);
    endcase
  endfunction : trig_of

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------- Bus slave
  logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic       aw_have_q, w_have_q, wlane_q;
  logic [2:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] mask_q, lctrl_q, fctrl_q, enh_q, rd_val;
  logic       rts_q, dtr_q;

  logic       wr_fire, wr_en, rd_fire, dlab, enh_sel;
  logic [2:0] ar_idx;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_en   = wr_fire & wlane_q;
  assign rd_fire = arvalid & arready_q;
  assign ar_idx  = araddr[4:2];
  assign dlab    = lctrl_q[LCTRL_DIV_BIT];
  assign enh_sel = (lctrl_q == LCTRL_ENH_KEY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 3'h0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= awaddr[4:2];
        awready_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wbyte_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
        wready_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (aw_idx_q == 3'h7) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register writes; the divisor bank hides holding and mask slots
  logic wr_hold, wr_mask, rd_hold, rd_ident, rd_lstate, rd_mstate;
  assign wr_hold   = wr_en & (aw_idx_q == IDX_HOLD) & ~dlab;
  assign wr_mask   = wr_en & (aw_idx_q == IDX_MASK) & ~dlab;
  assign rd_hold   = rd_fire & (ar_idx == IDX_HOLD) & ~dlab;
  assign rd_ident  = rd_fire & (ar_idx == IDX_IDENT) & ~enh_sel;
  assign rd_lstate = rd_fire & (ar_idx == IDX_LSTATE);
  assign rd_mstate = rd_fire & (ar_idx == IDX_MSTATE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q  <= MASK_RESET;
      lctrl_q <= LCTRL_RESET;
      fctrl_q <= 8'h00;
      enh_q   <= 8'h00;
      rts_q   <= 1'b0;
      dtr_q   <= 1'b0;
    end else if (wr_en) begin
      if (wr_mask) begin
        mask_q[3:0] <= wbyte_q[3:0];
        if (enh_q[ENH_UNLOCK_BIT]) begin
          mask_q[7:4] <= wbyte_q[7:4];
        end
      end
      if (aw_idx_q == IDX_LCTRL) begin
        lctrl_q <= wbyte_q;
      end
      if (aw_idx_q == IDX_IDENT && enh_sel) begin
        enh_q <= wbyte_q;
      end
      if (aw_idx_q == IDX_IDENT && !enh_sel) begin
        fctrl_q <= {wbyte_q[7:3], 2'b00, wbyte_q[FC_EN_BIT]};
      end
      if (aw_idx_q == IDX_MCTRL) begin
        rts_q <= wbyte_q[1];
        dtr_q <= wbyte_q[0];
      end
    end
  end

  // ---------------- Transmit path
  logic [7:0]    tx_mem [DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  logic          fifo_en, tx_push, tx_pop, tx_rst, rx_rst;
  uhr_ser_t      tx_st_q, rx_st_q;
  logic [15:0]   tick_cnt_q;
  logic          tick;

  assign fifo_en = fctrl_q[FC_EN_BIT];
  assign tx_rst  = wr_en & (aw_idx_q == IDX_IDENT) & ~enh_sel & wbyte_q[FC_TXRST_BIT];
  assign rx_rst  = wr_en & (aw_idx_q == IDX_IDENT) & ~enh_sel & wbyte_q[FC_RXRST_BIT];
  // A write to a full holding register is dropped
  assign tx_push = wr_hold & (tx_cnt_q < fifo_lim(fifo_en));
  assign tx_pop  = (tx_st_q == SER_IDLE) & (tx_cnt_q != '0);
  assign tick    = (tick_cnt_q == 16'(CLKS_PER_TICK - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= wbyte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || tx_rst) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      tx_wp_q  <= tx_wp_q + PW'(tx_push);
      tx_rp_q  <= tx_rp_q + PW'(tx_pop);
      tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
    end
  end

  logic [7:0] tx_sh_q;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic       txd_q, tx_bit_end;
  assign tx_bit_end = tick & (tx_sub_q == BIT_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q  <= SER_IDLE;
      tx_sh_q  <= 8'h00;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      txd_q    <= 1'b1;
    end else begin
      if (tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      case (tx_st_q)
        SER_IDLE: if (tx_pop) begin
          tx_sh_q  <= tx_mem[tx_rp_q];
          tx_sub_q <= 4'h0;
          txd_q    <= 1'b0;
          tx_st_q  <= SER_START;
        end
        SER_START: if (tx_bit_end) begin
          txd_q    <= tx_sh_q[0];
          tx_bit_q <= 3'h0;
          tx_st_q  <= SER_DATA;
        end
        SER_DATA: if (tx_bit_end) begin
          tx_sh_q  <= tx_sh_q >> 1;
          txd_q    <= (tx_bit_q == 3'h7) ? 1'b1 : tx_sh_q[1];
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == 3'h7) begin
            tx_st_q <= SER_STOP;
          end
        end
        SER_STOP: if (tx_bit_end) begin
          tx_st_q <= SER_IDLE;
        end
        default: tx_st_q <= SER_IDLE;
      endcase
    end
  end

  // ---------------- Receive path
  logic [4:0] in_m_q, in_s_q, in_p_q;
  logic       rx_fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_m_q <= 5'h01;
      in_s_q <= 5'h01;
      in_p_q <= 5'h01;
    end else begin
      in_m_q <= {cd_pin, ri_pin, dsr_pin, cts_pin, rxd};
      in_s_q <= in_m_q;
      in_p_q <= in_s_q;
    end
  end
  assign rx_fall = in_p_q[0] & ~in_s_q[0];

  logic [7:0] rx_sh_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q;
  logic       rx_end;
  assign rx_end = (rx_st_q == SER_STOP) & tick & (rx_sub_q == BIT_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q  <= SER_IDLE;
      rx_sh_q  <= 8'h00;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
    end else begin
      if (tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      case (rx_st_q)
        SER_IDLE: if (rx_fall) begin
          rx_sub_q <= 4'h0;
          rx_st_q  <= SER_START;
        end
        // Mid-bit check keeps a glitch from assembling a false character
        SER_START: if (tick && rx_sub_q == START_MID) begin
          rx_sub_q <= 4'h0;
          rx_bit_q <= 3'h0;
          rx_st_q  <= in_s_q[0] ? SER_IDLE : SER_DATA;
        end
        SER_DATA: if (tick && rx_sub_q == BIT_LAST) begin
          rx_sh_q  <= {in_s_q[0], rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) begin
            rx_st_q <= SER_STOP;
          end
        end
        SER_STOP: if (rx_end) begin
          rx_st_q <= SER_IDLE;
        end
        default: rx_st_q <= SER_IDLE;
      endcase
    end
  end

  logic [7:0]    rx_mem [DEPTH];
  logic [PW-1:0] rx_wp_q, rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic          rx_push, rx_pop, rx_frame;
  assign rx_push  = rx_end & (rx_cnt_q < fifo_lim(fifo_en));
  assign rx_pop   = rd_hold & (rx_cnt_q != '0);
  assign rx_frame = rx_end & ~in_s_q[0];

  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_sh_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_rst) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      rx_wp_q  <= rx_wp_q + PW'(rx_push);
      rx_rp_q  <= rx_rp_q + PW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // ---------------- Status and interrupt sources; a set always beats a clear
  uhr_lstate_t ls;
  logic       overrun_q, frame_q, brk_q, ferr_q, tx_int_q, xoff_q, cts_rise_q, rts_rise_q;
  logic       rts_p_q, rx_lvl;
  logic [3:0] delta_q;
  logic [7:0] src;
  logic [5:0] id_code;

  always_comb begin
    ls               = '0;
    ls.rx_ready      = (rx_cnt_q != '0);
    ls.overrun       = overrun_q;
    ls.frame         = frame_q;
    ls.brk           = brk_q;
    ls.fifo_err      = ferr_q;
    ls.tx_hold_empty = (tx_cnt_q == '0);
    ls.tx_all_empty  = (tx_cnt_q == '0) & (tx_st_q == SER_IDLE);
  end

  assign rx_lvl = fifo_en ? (rx_cnt_q >= trig_of(fctrl_q[7:6])) : ls.rx_ready;
  assign src    = {cts_rise_q, rts_rise_q, xoff_q, 1'b0, |delta_q,
                   |{ls.brk, ls.frame, ls.parity, ls.overrun}, tx_int_q, rx_lvl};

  always_comb begin
    if (src[2] && mask_q[2]) begin
      id_code = ID_LINE;
    end else if (src[0] && mask_q[0]) begin
      id_code = ID_RX;
    end else if (src[1] && mask_q[1]) begin
      id_code = ID_TX;
    end else if (src[3] && mask_q[3]) begin
      id_code = ID_MODEM;
    end else if (src[5] && mask_q[5]) begin
      id_code = ID_XOFF;
    end else if (|(src[7:6] & mask_q[7:6])) begin
      id_code = ID_FLOW;
    end else begin
      id_code = IDENT_NONE[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_q  <= 1'b0;
      frame_q    <= 1'b0;
      brk_q      <= 1'b0;
      ferr_q     <= 1'b0;
      delta_q    <= 4'h0;
      tx_int_q   <= 1'b1;
      xoff_q     <= 1'b0;
      cts_rise_q <= 1'b0;
      rts_rise_q <= 1'b0;
      rts_p_q    <= 1'b0;
    end else begin
      rts_p_q    <= rts_q;
      overrun_q  <= (rx_end & ~rx_push) | (overrun_q & ~rd_lstate);
      frame_q    <= rx_frame | (frame_q & ~rd_lstate);
      brk_q      <= (rx_frame & (rx_sh_q == 8'h00)) | (brk_q & ~rd_lstate);
      ferr_q     <= (rx_frame & fifo_en) | (ferr_q & ~rd_lstate);
      delta_q    <= (in_s_q[4:1] ^ in_p_q[4:1]) | (delta_q & {4{~rd_mstate}});
      tx_int_q   <= (tx_pop & (tx_cnt_q == CW'(1)) & ~tx_push)
                  | (tx_int_q & ~wr_hold & ~(rd_ident && id_code == ID_TX));
      xoff_q     <= (rx_push & (rx_sh_q == XOFF_CHAR))
                  | (xoff_q & ~(rd_ident && id_code == ID_XOFF));
      cts_rise_q <= (in_s_q[1] & ~in_p_q[1]) | (cts_rise_q & ~(rd_ident && id_code == ID_FLOW));
      rts_rise_q <= (rts_q & ~rts_p_q) | (rts_rise_q & ~(rd_ident && id_code == ID_FLOW));
    end
  end

  // ---------------- Pins
  logic irq_q, sleep_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q   <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      irq_q   <= |(src & mask_q);
      sleep_q <= mask_q[MASK_SLEEP_BIT] & ls.tx_all_empty
               & (rx_st_q == SER_IDLE) & (rx_cnt_q == '0);
    end
  end

  // ---------------- Read channel; side effects happen on address acceptance
  always_comb begin
    case (ar_idx)
      IDX_HOLD:   rd_val = (dlab || rx_cnt_q == '0) ? 8'h00 : rx_mem[rx_rp_q];
      IDX_MASK:   rd_val = dlab ? 8'h00
                         : {enh_q[ENH_UNLOCK_BIT] ? mask_q[7:4] : 4'h0, mask_q[3:0]};
      IDX_IDENT:  rd_val = enh_sel ? enh_q : {{2{fifo_en}}, id_code};
      IDX_LCTRL:  rd_val = lctrl_q;
      IDX_MCTRL:  rd_val = {6'h00, rts_q, dtr_q};
      IDX_LSTATE: rd_val = ls;
      IDX_MSTATE: rd_val = {in_s_q[4:1], delta_q};
      default:    rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_val};
      rresp_q   <= (ar_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign awready        = awready_q;
  assign wready         = wready_q;
  assign bvalid         = bvalid_q;
  assign bresp          = bresp_q;
  assign arready        = arready_q;
  assign rvalid         = rvalid_q;
  assign rdata          = rdata_q;
  assign rresp          = rresp_q;
  assign txd            = txd_q;
  assign rts_pin        = rts_q;
  assign dtr_pin        = dtr_q;
  assign sleep_out      = sleep_q;
  assign irq_out_chan_a = irq_q;

  // ---------------- Assertions
  property p_tx_write;
    wr_hold && tx_cnt_q == '0 |=> tx_cnt_q == CW'(1);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("holding write not queued");

  property p_tx_empty;
    tx_pop && tx_cnt_q == CW'(1) && !tx_push |=> ls.tx_hold_empty && tx_int_q;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("transmit empty not flagged");

  property p_rx_pop;
    rx_pop && !rx_push && !rx_rst |=> rx_cnt_q == $past(rx_cnt_q) - CW'(1);
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive read did not pop");

  property p_false_start;
    rx_st_q == SER_START && tick && rx_sub_q == START_MID && in_s_q[0] |=> rx_st_q == SER_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start accepted");

  property p_cts_irq;
    in_s_q[1] && !in_p_q[1] && mask_q[7] && $stable(mask_q) |-> ##2 irq_q;
  endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("CTS rise missed");

  property p_mask_reset;
    $rose(aresetn) |-> mask_q == MASK_RESET;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not reset");

  property p_rx_ready;
    rx_push |=> ls.rx_ready;
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("data ready not set");

  property p_irq_follow;
    |(src & mask_q) |=> irq_q;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt pin missed");

  // A mask write that leaves nothing enabled must drop the pin on the next clock
  property p_irq_drop;
    $changed(mask_q) && !(|(src & mask_q)) |=> !irq_q;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt pin stuck");

  property p_ident_rx;
    fifo_en && mask_q[0] && !(src[2] && mask_q[2]) && rx_cnt_q >= trig_of(fctrl_q[7:6])
      |-> id_code == ID_RX;
  endproperty
  a_ident_rx: assert property (p_ident_rx) else $error("ident lacks receive status");

  c_false_start: cover property (rx_st_q == SER_START ##1 rx_st_q == SER_IDLE);
  c_rx_byte:     cover property (rx_push);
  c_tx_done:     cover property (tx_st_q == SER_STOP ##1 tx_st_q == SER_IDLE);
  c_irq_rise:    cover property ($rose(irq_q));

endmodule : uhr_core

`default_nettype wire

// ==== uhr_line_model.sv ====
// Far-side serial line: sends frames on the receive pin, decodes the transmit pin
`timescale 1ns/1ps
`default_nettype none
module uhr_line_model
  import uhr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_q[$];
  logic [7:0] sh_q;
  initial rxd = 1'b1;
  // One bit is 16 clocks at one clock per tick; a low stop level forces a framing error
  task automatic send(input logic [7:0] b, input logic glitch, input logic stop_lvl);
    if (glitch) begin
      @(posedge aclk) rxd <= 1'b0;
      repeat (4) @(posedge aclk);
      rxd <= 1'b1;
      repeat (24) @(posedge aclk);
    end
    @(posedge aclk) rxd <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge aclk);
      rxd <= (i < 8) ? b[i] : stop_lvl;
    end
    repeat (16) @(posedge aclk);
    rxd <= 1'b1;
  endtask : send
  // Samples mid-bit, LSB first
  always begin
    @(negedge txd);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge aclk);
      sh_q[i] = txd;
    end
    got_q.push_back(sh_q);
    repeat (12) @(posedge aclk);
  end
endmodule : uhr_line_model
`default_nettype wire

// ==== uhr_core_test.sv ====
// Self-checking bench for the UART holding-register front end
`timescale 1ns/1ps
`default_nettype none
module uhr_core_test
  import uhr_pkg::*;
;
  localparam logic [7:0] STOP_CHAR = 8'h13;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cts_pin = 1'b0, dsr_pin = 1'b0;
  logic ri_pin = 1'b0, cd_pin = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'h1;
  logic [1:0]  bresp, bresp_seen, rresp, rresp_seen;
  logic        rxd, txd, rts_pin, dtr_pin, sleep_out, irq_out_chan_a;
  int miscompares = 0, total_checks = 0;
  always #5 aclk = ~aclk;
  uhr_core #(.CLKS_PER_TICK(1), .XOFF_CHAR(STOP_CHAR)) u_dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .cts_pin, .dsr_pin,
    .ri_pin, .cd_pin, .txd, .rts_pin, .dtr_pin, .sleep_out, .irq_out_chan_a);
  uhr_line_model u_line (.aclk, .txd, .rxd);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic timed_out;
    miscompares++;
    end_of_test();
  endtask : timed_out
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timed_out();
    bresp_seen = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timed_out();
    d = rdata[7:0];
    rresp_seen = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic chkrd(input logic [2:0] idx, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd(idx, v);
    chk(nm, v, exp);
  endtask : chkrd
  // Long enough for the pin synchronisers, the source flag and the output register
  task automatic irq_is(input logic e, input string nm);
    repeat (6) @(posedge aclk);
    chk(nm, irq_out_chan_a, e);
  endtask : irq_is
  initial begin
    logic [7:0] v, b;
    logic [7:0] exp_q[$];
    int n;
    void'($urandom(60806));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chkrd(IDX_MASK, MASK_RESET, "mask reset");
    chk("irq reset", irq_out_chan_a, 1'b0);
    wr(3'h7, 8'h00);
    chk("unmapped resp", bresp_seen, RESP_SLVERR);
    chkrd(3'h7, 8'h00, "unmapped read");
    chk("unmapped rresp", rresp_seen, RESP_SLVERR);
    wr(IDX_LCTRL, 8'h80);
    wr(IDX_MASK, 8'h0f);
    chkrd(IDX_MASK, 8'h00, "mask hidden");
    wr(IDX_LCTRL, 8'h00);
    chkrd(IDX_MASK, 8'h00, "mask kept");
    wr(IDX_MASK, 8'hff);
    chkrd(IDX_MASK, 8'h0f, "mask locked");
    wr(IDX_LCTRL, LCTRL_ENH_KEY);
    wr(IDX_IDENT, 8'h10);
    wr(IDX_LCTRL, 8'h00);
    wr(IDX_MASK, 8'h10);
    chkrd(IDX_MASK, 8'h10, "mask unlocked");
    repeat (4) @(posedge aclk);
    chk("sleep on", sleep_out, 1'b1);
    wr(IDX_IDENT, 8'h01);
    wr(IDX_MASK, 8'h02);
    // The pin register follows the mask one clock after the write lands
    repeat (2) @(posedge aclk);
    chk("sleep off", sleep_out, 1'b0);
    irq_is(1'b1, "tx empty irq");
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      wr(IDX_HOLD, b);
    end
    irq_is(1'b0, "tx irq cleared");
    rd(IDX_LSTATE, v);
    chk("tx held", v[5], 1'b0);
    for (n = 0; n < 3000 && u_line.got_q.size() < 3; n++) @(posedge aclk);
    if (n == 3000) timed_out();
    foreach (exp_q[i]) chk("tx byte", u_line.got_q[i], exp_q[i]);
    repeat (40) @(posedge aclk);
    rd(IDX_LSTATE, v);
    chk("tx empty flag", v[5], 1'b1);
    irq_is(1'b1, "tx irq again");
    wr(IDX_MASK, 8'h01);
    irq_is(1'b0, "tx irq masked");
    // Bit 4 clear keeps the byte off the stop character
    b = 8'($urandom) & 8'hef;
    u_line.send(b, 1'b1, 1'b1);
    repeat (4) @(posedge aclk);
    rd(IDX_LSTATE, v);
    chk("data ready", v[0], 1'b1);
    irq_is(1'b1, "rx irq");
    chkrd(IDX_IDENT, {2'b11, ID_RX}, "ident rx");
    wr(IDX_MASK, 8'h00);
    irq_is(1'b0, "rx masked");
    wr(IDX_MASK, 8'h01);
    irq_is(1'b1, "rx unmasked");
    chkrd(IDX_HOLD, b, "rx byte");
    rd(IDX_LSTATE, v);
    chk("data ready off", v[0], 1'b0);
    irq_is(1'b0, "rx irq off");
    wr(IDX_MASK, 8'h04);
    u_line.send(8'h00, 1'b0, 1'b0);
    irq_is(1'b1, "line error irq");
    rd(IDX_LSTATE, v);
    chk("break flags", v[4:3], 2'b11);
    irq_is(1'b0, "line error cleared");
    rd(IDX_HOLD, v);
    wr(IDX_MASK, 8'h08);
    dsr_pin <= 1'b1;
    irq_is(1'b1, "modem irq");
    chkrd(IDX_MSTATE, 8'h22, "modem state");
    irq_is(1'b0, "modem cleared");
    wr(IDX_MASK, 8'h40);
    wr(IDX_MCTRL, 8'h03);
    chk("rts pin", rts_pin, 1'b1);
    chk("dtr pin", dtr_pin, 1'b1);
    irq_is(1'b1, "rts irq");
    chkrd(IDX_IDENT, {2'b11, ID_FLOW}, "ident flow");
    irq_is(1'b0, "rts cleared");
    wr(IDX_MASK, 8'h80);
    cts_pin <= 1'b1;
    irq_is(1'b1, "cts irq");
    rd(IDX_IDENT, v);
    wr(IDX_MASK, 8'h20);
    irq_is(1'b0, "stop char idle");
    u_line.send(STOP_CHAR, 1'b0, 1'b1);
    irq_is(1'b1, "stop char irq");
    wr(IDX_MASK, 8'h00);
    irq_is(1'b0, "stop char masked");
    end_of_test();
  end
endmodule : uhr_core_test
`default_nettype wire
